// file: logic/event_counter_regs.svh
// Register offsets, field positions, reset values and timing counts of the event counter
`ifndef EVENT_COUNTER_REGS_SVH
`define EVENT_COUNTER_REGS_SVH
`define EDGE_SELECT_OFFSET 12'h000
`define CLOCK_SELECT_OFFSET 12'h004
`define CTRL_STATUS_OFFSET 12'h008
`define UPPER_COUNT_OFFSET 12'h00c
`define LOWER_COUNT_OFFSET 12'h010
`define IRQ_CTRL_OFFSET 12'h014
`define PRESCALER_OFFSET 12'h018
`define EDGE_SEL_LSB 0
`define PWM_ENABLE_BIT 2
`define CLK_SEL_LSB 0
`define OVF_FLAG_BIT 7
`define SPLIT_BIT 4
`define UPPER_EN_BIT 3
`define LOWER_EN_BIT 2
`define LOWER_RST_BIT 1
`define UPPER_RST_BIT 0
`define IRQ_ENABLE_BIT 0
`define IRQ_REQUEST_BIT 1
`define EDGE_SELECT_RESET 8'h00
`define CLOCK_SELECT_RESET 8'h00
`define CTRL_STATUS_RESET 8'h0f
`define EVENT_MAX_FREQ_HZ 2000000
`define SYS_CLOCK_HZ 125000000
`define MIN_EVENT_CYCLES ((`SYS_CLOCK_HZ + `EVENT_MAX_FREQ_HZ - 1) / `EVENT_MAX_FREQ_HZ)
`endif

// file: logic/event_counter_pkg.sv
// Types shared by the event counter files
package event_counter_pkg;
  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_BOTH = 2'b10,
    EDGE_NONE = 2'b11
  } edge_mode_e;
  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_PRE_LO = 2'b01,
    SRC_PRE_HI = 2'b10,
    SRC_OFF = 2'b11
  } clock_src_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RRESP = 2'b10
  } bus_state_e;
  typedef logic [7:0] count_byte_t;
endpackage : event_counter_pkg

// file: logic/edge_sense.sv
// Edge detector on a synchronous pin input
`timescale 1ns/1ps
`default_nettype none
module edge_sense (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic pin_i, // Sampled pin level
  input wire event_counter_pkg::edge_mode_e mode_i, // Which edges count
  output logic edge_o // One-cycle pulse per selected edge
);
  logic last;
  logic next_last;
  always_comb
  begin
    next_last = pin_i;
    unique case (mode_i)
      event_counter_pkg::EDGE_FALL: edge_o = last & ~pin_i;
      event_counter_pkg::EDGE_RISE: edge_o = ~last & pin_i;
      event_counter_pkg::EDGE_BOTH: edge_o = last ^ pin_i;
      event_counter_pkg::EDGE_NONE: edge_o = 1'b0;
    endcase
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      last <= 1'b1;
    else
      last <= next_last;
  end
endmodule // edge_sense
`default_nettype wire

// file: logic/count_byte.sv
// One 8-bit up-counter stage with hold-in-reset and carry out
`timescale 1ns/1ps
`default_nettype none
module count_byte (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic clear_i, // Hold at zero while high
  input wire logic tick_i, // Count one event
  input wire logic load_i, // Software write
  input wire logic [7:0] load_data_i, // Value written
  output logic [7:0] count_o, // Present count
  output logic carry_o // Pulse when wrapping from all ones
);
  logic [7:0] next_count;
  always_comb
  begin
    next_count = count_o;
    carry_o = 1'b0;
    if (clear_i)
      next_count = 8'h00;
    else if (load_i)
      next_count = load_data_i;
    else if (tick_i)
    begin
      next_count = count_o + 8'h01;
      carry_o = (count_o == 8'hff);
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_o <= 8'h00;
    else
      count_o <= next_count;
  end
endmodule // count_byte
`default_nettype wire

// file: logic/async_event_counter_16bit.sv
// Cascaded 16-bit event counter with AXI4-Lite register access
// Contract
// - Two 8-bit up-counters form one 16-bit count, upper and lower halves.
// - In cascaded mode the upper byte counts each lower-byte overflow.
// - With pin clock selected, lower byte counts each detected event pin edge.
// - Edge-sense select for the event pin; one setting detects falling edges only.
// - Clock select register picks the lower byte's source, pin events included.
// - Events are accepted only while the gate pin is high or edge select bit 2 (PWM enable) is set.
// - Overflow of the combined 16-bit count raises the interrupt request.
// - The request reaches the processor only when its enable is set.
// - Edge select register also halts PWM and selects gate pin enabling.
// - Control/status register has channel setting joining counters into 16 bits.
// - Separate count enables pass or block each counter's event clock.
// - Separate reset controls hold each counter in reset or release it.
// - Events up to 2 MHz are counted; count wraps every 65536 events.
// - A 13-bit prescaler increments every system clock cycle.
// - Upper overflow flag sets when upper byte wraps from all ones.
// - Flag clears only by writing zero after reading one; writing one ignored.
// - Split select zero runs both counters as one 16-bit counter.
// - Upper reset control one releases the upper counter to count.
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.svh"
module async_event_counter_16bit (
  input wire logic clock_i, // 125 MHz system clock
  input wire logic rst_n_i, // Asynchronous reset, active low
  input wire logic async_event_pin_low_i, // Event input pin
  input wire logic event_gate_pin_i, // Event enable level
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic overflow_irq_o // Gated overflow interrupt to the processor
);
  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  logic [7:0] edge_select_reg;
  logic [7:0] counter_clock_select_reg;
  logic [7:0] counter_ctrl_status_reg;
  logic overflow_irq_enable;
  logic overflow_irq_request;
  logic ovf_seen_one;
  logic [12:0] system_prescaler;
  logic [7:0] next_edge_select;
  logic [7:0] next_clock_select;
  logic [7:0] next_ctrl_status;
  logic next_irq_enable;
  logic next_irq_request;
  logic next_seen_one;
  logic read_arm;
  logic [12:0] next_prescaler;
  logic [7:0] upper_count_byte;
  logic [7:0] lower_count_byte;
  logic lower_carry;
  logic upper_carry;
  logic pin_edge;
  logic lower_tick;
  logic upper_tick;
  logic gate_open;
  logic [12:0] pre_last;
  logic src_event;
  logic write_fire;
  logic read_fire;
  logic [11:0] waddr;
  logic [31:0] wdata;
  logic wbyte0;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;
  event_counter_pkg::bus_state_e wstate;
  event_counter_pkg::bus_state_e rstate;
  event_counter_pkg::bus_state_e next_wstate;
  event_counter_pkg::bus_state_e next_rstate;
  logic next_aw_held;
  logic next_w_held;
  logic [11:0] next_aw_addr;
  logic [7:0] next_w_data;
  logic next_w_strb;

  edge_sense u_edge (
    .clock_i(clock_i),
    .rst_n_i(rst_sync_n),
    .pin_i(async_event_pin_low_i),
    .mode_i(event_counter_pkg::edge_mode_e'(edge_select_reg[`EDGE_SEL_LSB+1:`EDGE_SEL_LSB])),
    .edge_o(pin_edge)
  );

  // Prescaler taps offer slower internal sources in place of the pin
  always_comb
  begin
    pre_last = system_prescaler;
    next_prescaler = system_prescaler + 13'h0001;
    unique case (event_counter_pkg::clock_src_e'(counter_clock_select_reg[`CLK_SEL_LSB+1:`CLK_SEL_LSB]))
      event_counter_pkg::SRC_PIN: src_event = pin_edge;
      event_counter_pkg::SRC_PRE_LO: src_event = (pre_last[3:0] == 4'hf);
      event_counter_pkg::SRC_PRE_HI: src_event = (pre_last == 13'h1fff);
      event_counter_pkg::SRC_OFF: src_event = 1'b0;
    endcase
  end

  // Gate pin governs only while the PWM function is halted
  assign gate_open = edge_select_reg[`PWM_ENABLE_BIT] | event_gate_pin_i;
  assign lower_tick = src_event & gate_open & counter_ctrl_status_reg[`LOWER_EN_BIT];
  // Split mode feeds the upper byte from the same source as the lower one
  assign upper_tick = gate_open & counter_ctrl_status_reg[`UPPER_EN_BIT]
    & (counter_ctrl_status_reg[`SPLIT_BIT] ? src_event : lower_carry);

  count_byte u_lower (
    .clock_i(clock_i),
    .rst_n_i(rst_sync_n),
    .clear_i(~counter_ctrl_status_reg[`LOWER_RST_BIT]),
    .tick_i(lower_tick),
    .load_i(1'b0),
    .load_data_i(8'h00),
    .count_o(lower_count_byte),
    .carry_o(lower_carry)
  );

  count_byte u_upper (
    .clock_i(clock_i),
    .rst_n_i(rst_sync_n),
    .clear_i(~counter_ctrl_status_reg[`UPPER_RST_BIT]),
    .tick_i(upper_tick),
    .load_i(1'b0),
    .load_data_i(8'h00),
    .count_o(upper_count_byte),
    .carry_o(upper_carry)
  );

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = (wstate == event_counter_pkg::BUS_IDLE) & ~aw_held;
  assign s_axi_wready = (wstate == event_counter_pkg::BUS_IDLE) & ~w_held;
  assign s_axi_bvalid = (wstate == event_counter_pkg::BUS_WRESP);
  assign s_axi_arready = (rstate == event_counter_pkg::BUS_IDLE);
  assign s_axi_rvalid = (rstate == event_counter_pkg::BUS_RRESP);
  assign read_fire = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr_q;
    next_w_data = w_data_q;
    next_w_strb = w_strb_q;
    next_wstate = wstate;
    next_bresp = s_axi_bresp;
    write_fire = 1'b0;
    waddr = aw_addr_q;
    wdata = {24'h000000, w_data_q};
    wbyte0 = w_strb_q;
    if (s_axi_awvalid & s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
      waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_strb = s_axi_wstrb[0];
      wdata = s_axi_wdata;
      wbyte0 = s_axi_wstrb[0];
    end
    unique case (wstate)
      event_counter_pkg::BUS_IDLE:
        if (next_aw_held & next_w_held)
        begin
          write_fire = 1'b1;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wstate = event_counter_pkg::BUS_WRESP;
          next_bresp = (waddr > `PRESCALER_OFFSET || waddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
        end
      event_counter_pkg::BUS_WRESP:
        if (s_axi_bready)
          next_wstate = event_counter_pkg::BUS_IDLE;
      default:
        next_wstate = event_counter_pkg::BUS_IDLE;
    endcase
  end

  always_comb
  begin
    next_rstate = rstate;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    read_arm = 1'b0;
    unique case (rstate)
      event_counter_pkg::BUS_IDLE:
        if (read_fire)
        begin
          next_rstate = event_counter_pkg::BUS_RRESP;
          next_rresp = 2'b00;
          unique case (s_axi_araddr)
            `EDGE_SELECT_OFFSET: next_rdata = {24'h000000, edge_select_reg};
            `CLOCK_SELECT_OFFSET: next_rdata = {24'h000000, counter_clock_select_reg};
            `CTRL_STATUS_OFFSET:
            begin
              next_rdata = {24'h000000, counter_ctrl_status_reg};
              if (counter_ctrl_status_reg[`OVF_FLAG_BIT])
                read_arm = 1'b1;
            end
            `UPPER_COUNT_OFFSET: next_rdata = {24'h000000, upper_count_byte};
            `LOWER_COUNT_OFFSET: next_rdata = {24'h000000, lower_count_byte};
            `IRQ_CTRL_OFFSET: next_rdata = {30'h00000000, overflow_irq_request, overflow_irq_enable};
            `PRESCALER_OFFSET: next_rdata = {19'h00000, system_prescaler};
            default:
            begin
              next_rdata = 32'h00000000;
              next_rresp = 2'b10;
            end
          endcase
        end
      event_counter_pkg::BUS_RRESP:
        if (s_axi_rready)
          next_rstate = event_counter_pkg::BUS_IDLE;
      default:
        next_rstate = event_counter_pkg::BUS_IDLE;
    endcase
  end

  // Register file; hardware sets win over software clears
  always_comb
  begin
    next_edge_select = edge_select_reg;
    next_clock_select = counter_clock_select_reg;
    next_ctrl_status = counter_ctrl_status_reg;
    next_irq_enable = overflow_irq_enable;
    next_irq_request = overflow_irq_request;
    // The arm lives with the flag so the read and the write path share one driver
    next_seen_one = ovf_seen_one | read_arm;
    if (write_fire & wbyte0)
    begin
      unique case (waddr)
        `EDGE_SELECT_OFFSET: next_edge_select = {5'h00, wdata[2:0]};
        `CLOCK_SELECT_OFFSET: next_clock_select = {6'h00, wdata[1:0]};
        `CTRL_STATUS_OFFSET:
        begin
          next_ctrl_status = {counter_ctrl_status_reg[7], 2'b00, wdata[4:0]};
          if (!wdata[`OVF_FLAG_BIT] && ovf_seen_one)
          begin
            next_ctrl_status[`OVF_FLAG_BIT] = 1'b0;
            next_seen_one = 1'b0;
          end
        end
        `IRQ_CTRL_OFFSET:
        begin
          next_irq_enable = wdata[`IRQ_ENABLE_BIT];
          if (!wdata[`IRQ_REQUEST_BIT])
            next_irq_request = 1'b0;
        end
        default: next_edge_select = edge_select_reg;
      endcase
    end
    if (upper_carry)
    begin
      next_ctrl_status[`OVF_FLAG_BIT] = 1'b1;
      if (!counter_ctrl_status_reg[`SPLIT_BIT])
        next_irq_request = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      edge_select_reg <= `EDGE_SELECT_RESET;
      counter_clock_select_reg <= `CLOCK_SELECT_RESET;
      counter_ctrl_status_reg <= `CTRL_STATUS_RESET;
      overflow_irq_enable <= 1'b0;
      overflow_irq_request <= 1'b0;
      ovf_seen_one <= 1'b0;
      system_prescaler <= 13'h0000;
      wstate <= event_counter_pkg::BUS_IDLE;
      rstate <= event_counter_pkg::BUS_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
      overflow_irq_o <= 1'b0;
    end
    else
    begin
      edge_select_reg <= next_edge_select;
      counter_clock_select_reg <= next_clock_select;
      counter_ctrl_status_reg <= next_ctrl_status;
      overflow_irq_enable <= next_irq_enable;
      overflow_irq_request <= next_irq_request;
      ovf_seen_one <= next_seen_one;
      system_prescaler <= next_prescaler;
      wstate <= next_wstate;
      rstate <= next_rstate;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr;
      w_data_q <= next_w_data;
      w_strb_q <= next_w_strb;
      s_axi_bresp <= next_bresp;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      overflow_irq_o <= next_irq_request & next_irq_enable;
    end
  end

  a_upper_cascade: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (lower_carry && upper_tick && counter_ctrl_status_reg[`UPPER_RST_BIT])
      |=> upper_count_byte == $past(upper_count_byte) + 8'h01)
    else $error("upper byte missed lower carry");
  a_gate_hold: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (!event_gate_pin_i && !edge_select_reg[`PWM_ENABLE_BIT] && counter_ctrl_status_reg[1:0] == 2'b11)
      |=> $stable(lower_count_byte) && $stable(upper_count_byte))
    else $error("count moved with gate low");
  a_pin_count: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (pin_edge && lower_tick && counter_ctrl_status_reg[`LOWER_RST_BIT])
      |=> lower_count_byte == $past(lower_count_byte) + 8'h01)
    else $error("pin edge not counted");
  a_irq_raise: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    (upper_carry && !counter_ctrl_status_reg[`SPLIT_BIT]) |=> overflow_irq_request)
    else $error("overflow did not raise request");
  a_irq_gate: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    overflow_irq_o == (overflow_irq_request && overflow_irq_enable))
    else $error("interrupt passed while disabled");
  a_flag_set: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    upper_carry |=> counter_ctrl_status_reg[`OVF_FLAG_BIT])
    else $error("overflow flag not set");
  a_flag_clear: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    ($fell(counter_ctrl_status_reg[`OVF_FLAG_BIT])) |-> $past(ovf_seen_one) && $past(write_fire))
    else $error("flag cleared without read-then-zero");
  a_upper_reset: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    !counter_ctrl_status_reg[`UPPER_RST_BIT] ##1 !counter_ctrl_status_reg[`UPPER_RST_BIT]
      |-> upper_count_byte == 8'h00)
    else $error("upper byte not held in reset");
  a_prescale: assert property (@(posedge clock_i) disable iff (!rst_sync_n)
    rst_sync_n |=> system_prescaler == $past(system_prescaler) + 13'h0001)
    else $error("prescaler skipped");
endmodule // async_event_counter_16bit
`default_nettype wire

// file: test/event_source.sv
// Event pulse source and gate level that feed the event counter
`timescale 1ns/1ps
`default_nettype none
module event_source (
  output logic pin_o, // Event pin level, idles high
  output logic gate_o, // Gate level, high lets events in
  input wire logic clock_i // System clock
);
  initial
  begin
    pin_o = 1'b1;
    gate_o = 1'b1;
  end
  task automatic set_gate(input logic g);
    @(posedge clock_i);
    gate_o <= g;
  endtask
  // One low pulse per event; gap sets how slowly the source answers
  task automatic pulses(input int n, input int gap);
    repeat (n)
    begin
      @(posedge clock_i);
      pin_o <= 1'b0;
      repeat (gap) @(posedge clock_i);
      pin_o <= 1'b1;
      repeat (gap) @(posedge clock_i);
    end
    repeat (4) @(posedge clock_i);
  endtask
  // Level change every cycle, above the rated rate, so a full wrap fits the run
  task automatic toggles(input int n);
    repeat (n)
    begin
      @(posedge clock_i);
      pin_o <= ~pin_o;
    end
    repeat (4) @(posedge clock_i);
  endtask
endmodule // event_source
`default_nettype wire

// file: test/async_event_counter_16bit_test.sv
// Self-checking bench for the cascaded event counter
`timescale 1ns/1ps
`default_nettype none
`include "event_counter_regs.svh"
module async_event_counter_16bit_test;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic async_event_pin_low_i, event_gate_pin_i;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ar_cyc;
  int seed = 28;
  int model_cnt = 0;
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;
  async_event_counter_16bit i_async_event_counter_16bit (
    .clock_i, .rst_n_i, .async_event_pin_low_i, .event_gate_pin_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .overflow_irq_o
  );
  event_source i_event_source (
    .pin_o(async_event_pin_low_i),
    .gate_o(event_gate_pin_i),
    .clock_i(clock_i)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic timed_out();
    err_count++;
    $display("[FAIL] bus answer expected 1 seen 0");
    finish_test();
  endtask
  // Ready and valid are looked at mid-cycle, where they are settled for the next edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic pa, pw, pb;
    int n;
    pb = 1'b0;
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64 && !pb; n++)
    begin
      @(negedge clock_i);
      pa = s_axi_awvalid && s_axi_awready;
      pw = s_axi_wvalid && s_axi_wready;
      pb = s_axi_bready && s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clock_i);
      if (pa) s_axi_awvalid <= 1'b0;
      if (pw) s_axi_wvalid <= 1'b0;
      if (pb) s_axi_bready <= 1'b0;
    end
    if (!pb) timed_out();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic pa, pr;
    int n;
    pr = 1'b0;
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64 && !pr; n++)
    begin
      @(negedge clock_i);
      pa = s_axi_arvalid && s_axi_arready;
      pr = s_axi_rready && s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      if (pa) ar_cyc = cyc;
      @(posedge clock_i);
      if (pa) s_axi_arvalid <= 1'b0;
      if (pr) s_axi_rready <= 1'b0;
    end
    if (!pr) timed_out();
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(what, d, exp);
    check("read resp", r, 2'b00);
  endtask
  task automatic wok(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("write resp", r, 2'b00);
  endtask
  task automatic counts(input string what);
    rchk(`LOWER_COUNT_OFFSET, model_cnt & 32'hff, what);
    rchk(`UPPER_COUNT_OFFSET, (model_cnt >> 8) & 32'hff, what);
    $display("test %s done", what);
  endtask
  task automatic burst(input int n);
    i_event_source.pulses(n, 1 + $unsigned($random(seed)) % 3);
  endtask
  initial
  begin
    logic [31:0] d1, d2;
    logic [1:0] r;
    int n, m, c1;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rchk(`EDGE_SELECT_OFFSET, 32'h0, "edge select reset");
    rchk(`CLOCK_SELECT_OFFSET, 32'h0, "clock select reset");
    rchk(`CTRL_STATUS_OFFSET, 32'h0f, "ctrl reset");
    rchk(`IRQ_CTRL_OFFSET, 32'h0, "irq ctrl reset");
    rd(12'h01c, d1, r);
    check("unmapped read resp", r, 2'b10);
    check("unmapped read data", d1, 32'h0);
    wr(12'h01c, 32'hff, r);
    check("unmapped write resp", r, 2'b10);
    @(posedge clock_i);
    s_axi_wstrb <= 4'he;
    wok(`EDGE_SELECT_OFFSET, 32'h3);
    rchk(`EDGE_SELECT_OFFSET, 32'h0, "byte 0 not strobed");
    s_axi_wstrb <= 4'hf;
    counts("reset");
    // Every edge mode with a random count of slow and quick pulses
    for (m = 0; m < 4; m++)
    begin
      wok(`EDGE_SELECT_OFFSET, m);
      n = 1 + $unsigned($random(seed)) % 8;
      burst(n);
      model_cnt += (m < 2) ? n : (m == 2) ? 2 * n : 0;
      counts("edge mode");
    end
    wok(`EDGE_SELECT_OFFSET, 32'h0);
    i_event_source.set_gate(1'b0);
    burst(3);
    counts("gate low");
    wok(`EDGE_SELECT_OFFSET, 32'h04);
    burst(2);
    model_cnt += 2;
    counts("gate ignored");
    wok(`EDGE_SELECT_OFFSET, 32'h0);
    i_event_source.set_gate(1'b1);
    wok(`CTRL_STATUS_OFFSET, 32'h0b);
    burst(3);
    counts("lower disabled");
    wok(`CLOCK_SELECT_OFFSET, 32'h3);
    wok(`CTRL_STATUS_OFFSET, 32'h0f);
    burst(3);
    counts("source off");
    // Both prescaler taps; the source stays selected for the repeat count plus three cycles
    for (m = 1; m < 3; m++)
    begin
      wok(`CLOCK_SELECT_OFFSET, m);
      repeat ((m == 1) ? 157 : 8189) @(posedge clock_i);
      wok(`CLOCK_SELECT_OFFSET, 32'h3);
      model_cnt += (m == 1) ? 10 : 1;
      counts("prescaler source");
    end
    wok(`CLOCK_SELECT_OFFSET, 32'h0);
    wok(`CTRL_STATUS_OFFSET, 32'h1f);
    burst(3);
    model_cnt += 32'h0303;
    counts("split mode");
    wok(`CTRL_STATUS_OFFSET, 32'h0c);
    model_cnt = 0;
    counts("held in reset");
    rd(`PRESCALER_OFFSET, d1, r);
    c1 = ar_cyc;
    rd(`PRESCALER_OFFSET, d2, r);
    check("prescaler step", (d2 - d1) & 32'hff, (ar_cyc - c1) & 32'hff);
    wok(`CTRL_STATUS_OFFSET, 32'h0f);
    wok(`IRQ_CTRL_OFFSET, 32'h01);
    wok(`EDGE_SELECT_OFFSET, 32'h2);
    i_event_source.toggles(256);
    model_cnt = 256;
    counts("lower wrap");
    @(negedge clock_i);
    check("irq before wrap", overflow_irq_o, 1'b0);
    i_event_source.toggles(65280);
    model_cnt = 0;
    counts("full wrap");
    @(negedge clock_i);
    check("irq after wrap", overflow_irq_o, 1'b1);
    // Flag must survive a one written and a zero written before it was read
    wok(`CTRL_STATUS_OFFSET, 32'h8f);
    wok(`CTRL_STATUS_OFFSET, 32'h0f);
    rchk(`CTRL_STATUS_OFFSET, 32'h8f, "flag kept");
    wok(`CTRL_STATUS_OFFSET, 32'h0f);
    rchk(`CTRL_STATUS_OFFSET, 32'h0f, "flag cleared");
    wok(`IRQ_CTRL_OFFSET, 32'h02);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    check("irq masked", overflow_irq_o, 1'b0);
    rchk(`IRQ_CTRL_OFFSET, 32'h02, "request kept");
    wok(`IRQ_CTRL_OFFSET, 32'h00);
    rchk(`IRQ_CTRL_OFFSET, 32'h00, "request cleared");
    $display("test overflow done");
    finish_test();
  end
endmodule // async_event_counter_16bit_test
`default_nettype wire
